//--- dv/shtt_far_model.sv
// Purpose: protection/attribution lookup and wake-source model beside the unit
// Assumes: r is set at the edge that offers an instruction and read with it
// Notes: lookups packed in one vector to keep the bench small; wakes held 5 cycles, past the 2-flop sync
`default_nettype none
module shtt_far_model (
    // clock and stimulus
    input wire logic core_clk,
    input wire logic [31:0] r,
    input wire logic [5:0] kick,
    // lookup levels and wake lines
    output logic [35:0] look,
    output logic [5:0] wake
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_reg;
    // biased so that present, enabled, single-hit lookups are common
    assign look = {r[23] & r[24], ~r[31:24], r[22], r[21], r[31:24], r[20], r[19:16], r[15:8],
                   r[6] & r[7], r[4] | r[5], r[2] | r[3], r[0] | r[1]};
    initial cnt_reg = 3'h0;
    initial wake = 6'h00;
    always @(posedge core_clk) begin
        if (kick != 6'h00) begin
            wake <= kick;
            cnt_reg <= 3'h4;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end else begin
            wake <= 6'h00;
        end
    end
endmodule
`default_nettype wire

//--- dv/test_shtt_unit.sv
// Purpose: self-checking bench for the system hint and target test unit
// Assumes: result pulses coincide with op_done
// Notes: expected results queued by the driver, popped by the monitor at op_done
`default_nettype none
`include "shtt_cfg.svh"
module test_shtt_unit import shtt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, resetn, op_valid, psel, penable, pwrite, pready, pslverr, er, sec_ext;
    logic op_done, tt_result_valid, flags_write, sg_valid_target, svc_exc, undef_fault, event_out;
    logic yield_hint, sleeping;
    shtt_op_t op_code;
    logic [2:0] mode;
    logic [5:0] kick, wake;
    logic [35:0] look;
    logic [11:0] paddr;
    logic [31:0] r, pwdata, prdata, rd, tt_result, last_tt;
    logic [37:0] q[$];
    logic [37:0] exp_v;
    int n_fail, cmp_count;
    int wk[7] = '{1, 2, 5, 0, 3, 4, 5};
    shtt_op_t misc[4] = '{SHTT_OP_SECURE_GATEWAY, SHTT_OP_SVC, SHTT_OP_UNDEF, SHTT_OP_YIELD};
    logic [37:0] mexp[4] = '{38'h08_0000_0000, 38'h10_0000_0000, 38'h20_0000_0000, 38'h02_0000_0000};
    shtt_far_model i_shtt_far_model (.core_clk(core_clk), .r(r), .kick(kick), .look(look), .wake(wake));
    shtt_unit i_shtt_unit (.core_clk(core_clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
        .cur_secure(mode[0]), .cur_priv(mode[1]), .ns_priv(mode[2]), .mpu_present(look[0]),
        .mpu_enable(look[1]), .mpu_hit(look[2]), .mpu_multi(look[3]), .mpu_region(look[11:4]),
        .mpu_rd_priv(look[12]), .mpu_wr_priv(look[13]), .mpu_rd_unpriv(look[14]), .mpu_wr_unpriv(look[15]),
        .sau_valid(look[16]), .sau_region(look[24:17]), .loc_secure(look[25]), .implementation_defined_attribution_unit_valid(look[26]),
        .implementation_defined_attribution_unit_region(look[34:27]), .implementation_defined_attribution_unit_exempt(look[35]), .event_in(wake[0]), .exc_unmasked(wake[1]),
        .exc_pending_new(wake[2]), .irq_taken(wake[3]), .irq_masked_pend(wake[4]), .debug_req(wake[5]),
        .op_done(op_done), .tt_result(tt_result), .tt_result_valid(tt_result_valid),
        .flags_write(flags_write), .sg_valid_target(sg_valid_target), .svc_exc(svc_exc),
        .undef_fault(undef_fault), .event_out(event_out), .yield_hint(yield_hint), .sleeping(sleeping),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;
    task automatic chk(logic ok, string m);
        cmp_count++;
        if (!ok) begin
            n_fail++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [37:0] tt_exp(shtt_op_t c);
        logic alt, up, pv, sec, mv, rd_b, rw_b, s, sv, iv;
        alt = (c == SHTT_OP_TEST_TARGET_ALT) || (c == SHTT_OP_TEST_TARGET_ALT_UNPRIV);
        up = (c == SHTT_OP_TEST_TARGET_UNPRIV) || (c == SHTT_OP_TEST_TARGET_ALT_UNPRIV);
        if (alt && !(mode[0] && sec_ext)) return 38'h20_0000_0000;
        pv = alt ? mode[2] : mode[1];
        sec = mode[0] & sec_ext;
        mv = look[0] & look[1] & look[2] & !look[3] & pv;
        rd_b = !look[3] & pv & (up ? look[14] : look[12]);
        rw_b = rd_b & (up ? look[15] : look[13]);
        s = sec & look[25];
        sv = sec & look[16];
        iv = sec & look[26] & !look[35];
        return {6'h01, iv ? look[34:27] : 8'h00, iv, s, rw_b & !s & mode[0], rd_b & !s & mode[0], rw_b, rd_b, sv, mv,
                sv ? look[24:17] : 8'h00, mv ? look[11:4] : 8'h00};
    endfunction
    task automatic do_op(shtt_op_t c, logic tt, logic [37:0] e);
        logic [37:0] x;
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= c;
        r <= $urandom();
        mode <= 3'($urandom());
        @(posedge core_clk);
        x = tt ? tt_exp(c) : e;
        if (x[32]) last_tt = x[31:0];
        q.push_back(x);
        op_valid <= 1'b0;
    endtask
    task automatic wait_q();
        for (int i = 0; i < 50 && q.size() != 0; i++) @(posedge core_clk);
        chk(q.size() == 0, "no completion");
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic sleep_wake(shtt_op_t c, int k);
        do_op(c, 1'b0, 38'h0);
        repeat (3) @(posedge core_clk);
        chk(sleeping === 1'b1, "not suspended");
        kick <= 6'(1 << k);
        @(posedge core_clk);
        kick <= 6'h00;
        wait_q();
        chk(sleeping === 1'b0, "still suspended");
    endtask
    always @(posedge core_clk) begin
        if (op_done === 1'b1) begin
            chk(q.size() != 0, "unexpected completion");
            exp_v = q.size() != 0 ? q.pop_front() : 38'h0;
            chk({undef_fault, svc_exc, sg_valid_target, event_out, yield_hint, tt_result_valid,
                 tt_result_valid ? tt_result : 32'h0} === exp_v, "op result");
            chk(flags_write === 1'b0, "flags written");
        end
    end
    initial begin
        {resetn, op_valid, psel, penable, pwrite, paddr, pwdata, r, mode, kick, last_tt} = '0;
        op_code = SHTT_OP_NONE;
        sec_ext = 1'b1;
        void'($urandom(32'h3b4cfa57));
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        apb(1'b0, `SHTT_OFF_CTRL, 32'h0);
        chk(rd === 32'h0000_0006 && er === 1'b0, "ctrl reset value");
        apb(1'b0, 12'h00c, 32'h0);
        chk(er === 1'b1 && rd === 32'h0, "unmapped access");
        do_op(SHTT_OP_SEND_EVENT, 1'b0, 38'h04_0000_0000);
        wait_q();
        apb(1'b0, `SHTT_OFF_STAT, 32'h0);
        chk(rd[1] === 1'b1, "event flag not set");
        do_op(SHTT_OP_WAIT_EVENT, 1'b0, 38'h0);
        repeat (2) @(posedge core_clk);
        chk(q.size() == 0 && sleeping === 1'b0, "wait with flag set");
        apb(1'b1, `SHTT_OFF_CTRL, 32'h0000_0007);
        for (int i = 0; i < 7; i++) sleep_wake(i < 4 ? SHTT_OP_WAIT_EVENT : SHTT_OP_WAIT_INTR, wk[i]);
        for (int i = 0; i < 4; i++) do_op(misc[i], 1'b0, mexp[i]);
        for (int p = 0; p < 2; p++) begin
            wait_q();
            apb(1'b1, `SHTT_OFF_CTRL, p == 0 ? 32'h0000_0007 : 32'h0000_0003);
            sec_ext = (p == 0);
            for (int i = 0; i < 40; i++) do_op(shtt_op_t'(4'(4 + $urandom_range(3))), 1'b1, 38'h0);
        end
        wait_q();
        apb(1'b0, `SHTT_OFF_TTRES, 32'h0);
        chk(rd === last_tt && er === 1'b0, "result register");
        complete_run();
    end
    initial begin
        #(20000 * 50);
        n_fail++;
        complete_run();
    end
endmodule
`default_nettype wire

//--- logic/shtt_cfg.svh
// Purpose: constants for the system hint and target test unit
// Assumes: included by the bench and the design
// Notes: offsets are byte addresses on the apb slave
`ifndef SHTT_CFG_SVH
`define SHTT_CFG_SVH
`define SHTT_OFF_CTRL 12'h000
`define SHTT_OFF_STAT 12'h004
`define SHTT_OFF_TTRES 12'h008
`define SHTT_CTRL_WAKE_ON_PEND 0
`define SHTT_CTRL_DEBUG_EN 1
`define SHTT_CTRL_SEC_EXT 2
`define SHTT_CTRL_RESET 32'h0000_0006
`define SHTT_TT_MREG_LSB 0
`define SHTT_TT_SREG_LSB 8
`define SHTT_TT_PROTECTION_REGION_VALID 16
`define SHTT_TT_ATTRIBUTION_REGION_VALID 17
`define SHTT_TT_R 18
`define SHTT_TT_RW 19
`define SHTT_TT_NSR 20
`define SHTT_TT_NONSECURE_READ_WRITABLE 21
`define SHTT_TT_S 22
`define SHTT_TT_IMPL_REGION_VALID 23
`define SHTT_TT_IREG_LSB 24
`endif

//--- logic/shtt_pkg.sv
// Purpose: types for the system hint and target test unit
// Assumes: nothing
// Notes: opcode encoding is internal to the execute stage
`default_nettype none
package shtt_pkg;
    typedef enum logic [3:0] {
        SHTT_OP_NONE, SHTT_OP_SEND_EVENT, SHTT_OP_SECURE_GATEWAY, SHTT_OP_SVC,
        SHTT_OP_TEST_TARGET, SHTT_OP_TEST_TARGET_UNPRIV, SHTT_OP_TEST_TARGET_ALT,
        SHTT_OP_TEST_TARGET_ALT_UNPRIV, SHTT_OP_UNDEF, SHTT_OP_WAIT_EVENT,
        SHTT_OP_WAIT_INTR, SHTT_OP_YIELD
    } shtt_op_t;
    typedef enum {SHTT_RUN, SHTT_WAIT_EV, SHTT_WAIT_IRQ} shtt_state_t;
endpackage
`default_nettype wire

//--- logic/shtt_unit.sv
// Purpose: executes the system hint and test-target instructions
// Assumes: one instruction offered per op_valid pulse; protection lookups are combinational inputs
// Notes: apb slave holds control bits, sleep status and the last test-target result
//
// Design decisions made here: the APB slave port and the address map.
`default_nettype none
`include "shtt_cfg.svh"
module shtt_unit import shtt_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // instruction from execute
    input wire logic op_valid,
    input wire shtt_op_t op_code,
    input wire logic cur_secure,
    input wire logic cur_priv,
    input wire logic ns_priv,
    // protection unit lookup
    input wire logic mpu_present,
    input wire logic mpu_enable,
    input wire logic mpu_hit,
    input wire logic mpu_multi,
    input wire logic [7:0] mpu_region,
    input wire logic mpu_rd_priv,
    input wire logic mpu_wr_priv,
    input wire logic mpu_rd_unpriv,
    input wire logic mpu_wr_unpriv,
    // attribution lookup
    input wire logic sau_valid,
    input wire logic [7:0] sau_region,
    input wire logic loc_secure,
    input wire logic implementation_defined_attribution_unit_valid,
    input wire logic [7:0] implementation_defined_attribution_unit_region,
    input wire logic implementation_defined_attribution_unit_exempt,
    // wake sources, from other domains
    input wire logic event_in,
    input wire logic exc_unmasked,
    input wire logic exc_pending_new,
    input wire logic irq_taken,
    input wire logic irq_masked_pend,
    input wire logic debug_req,
    // results to execute and exception logic
    output logic op_done,
    output logic [31:0] tt_result,
    output logic tt_result_valid,
    output logic flags_write,
    output logic sg_valid_target,
    output logic svc_exc,
    output logic undef_fault,
    output logic event_out,
    output logic yield_hint,
    output logic sleeping,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef struct packed {
        logic [1:0] ev_s1, ev_s2, exc_s1, exc_s2, pend_s1, pend_s2;
        logic [1:0] irq_s1, irq_s2, mpend_s1, mpend_s2, dbg_s1, dbg_s2;
        shtt_state_t state;
        logic event_reg;
        logic [31:0] ctrl_reg;
        logic op_done, tt_valid, sg, svc, undef, ev_out, yield, sleeping;
        logic [31:0] tt;
        logic [31:0] prdata;
        logic pready, pslverr;
    } shtt_st_t;

    shtt_st_t st_reg, st_next;
    logic [1:0] rst_sync_reg;
    logic rst_n;
    assign rst_n = rst_sync_reg[1];

    // reset release through two flops; kept apart from the struct as it runs on the pin reset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // synchronised wake inputs: stage 1 read only by stage 2
    logic w_ev, w_exc, w_pend, w_irq, w_mpend, w_dbg;
    assign w_ev = st_reg.ev_s2[0];
    assign w_exc = st_reg.exc_s2[0];
    assign w_pend = st_reg.pend_s2[0];
    assign w_irq = st_reg.irq_s2[0];
    assign w_mpend = st_reg.mpend_s2[0];
    assign w_dbg = st_reg.dbg_s2[0];

    logic sec_ext, dbg_en, wake_pend;
    assign sec_ext = st_reg.ctrl_reg[`SHTT_CTRL_SEC_EXT];
    assign dbg_en = st_reg.ctrl_reg[`SHTT_CTRL_DEBUG_EN];
    assign wake_pend = st_reg.ctrl_reg[`SHTT_CTRL_WAKE_ON_PEND];

    // test target result, combinational from lookups
    logic [31:0] tt_calc;
    logic is_alt, is_unp, tt_unpriv, tt_rd, tt_rw, mreg_ok, sreg_ok, s_bit, ir_ok;
    always_comb begin
        is_alt = (op_code == SHTT_OP_TEST_TARGET_ALT) || (op_code == SHTT_OP_TEST_TARGET_ALT_UNPRIV);
        is_unp = (op_code == SHTT_OP_TEST_TARGET_UNPRIV) || (op_code == SHTT_OP_TEST_TARGET_ALT_UNPRIV);
        // every query, plain or alternate and either variant, invalid when the relevant mode is unprivileged
        tt_unpriv = is_alt ? !ns_priv : !cur_priv;
        mreg_ok = mpu_present && mpu_enable && mpu_hit && !mpu_multi && !tt_unpriv;
        // unprivileged variants see unprivileged permissions even when privileged
        tt_rd = is_unp ? mpu_rd_unpriv : mpu_rd_priv;
        tt_rw = is_unp ? (mpu_rd_unpriv && mpu_wr_unpriv) : (mpu_rd_priv && mpu_wr_priv);
        if (mpu_multi || tt_unpriv) begin
            tt_rd = 1'b0;
            tt_rw = 1'b0;
        end
        sreg_ok = sec_ext && cur_secure && sau_valid;
        s_bit = sec_ext && cur_secure && loc_secure;
        ir_ok = sec_ext && cur_secure && implementation_defined_attribution_unit_valid && !implementation_defined_attribution_unit_exempt;
        tt_calc = 32'h0000_0000;
        tt_calc[`SHTT_TT_MREG_LSB +: 8] = mreg_ok ? mpu_region : 8'h00;
        tt_calc[`SHTT_TT_SREG_LSB +: 8] = sreg_ok ? sau_region : 8'h00;
        tt_calc[`SHTT_TT_PROTECTION_REGION_VALID] = mreg_ok;
        tt_calc[`SHTT_TT_ATTRIBUTION_REGION_VALID] = sreg_ok;
        tt_calc[`SHTT_TT_R] = tt_rd;
        tt_calc[`SHTT_TT_RW] = tt_rw;
        tt_calc[`SHTT_TT_NSR] = tt_rd && !s_bit && cur_secure;
        tt_calc[`SHTT_TT_NONSECURE_READ_WRITABLE] = tt_rw && !s_bit && cur_secure;
        tt_calc[`SHTT_TT_S] = s_bit;
        tt_calc[`SHTT_TT_IMPL_REGION_VALID] = ir_ok;
        tt_calc[`SHTT_TT_IREG_LSB +: 8] = ir_ok ? implementation_defined_attribution_unit_region : 8'h00;
    end

    logic apb_acc;
    assign apb_acc = psel && penable && !st_reg.pready;

    always_comb begin
        st_next = st_reg;
        st_next.ev_s1 = {1'b0, event_in};
        st_next.ev_s2 = st_reg.ev_s1;
        st_next.exc_s1 = {1'b0, exc_unmasked};
        st_next.exc_s2 = st_reg.exc_s1;
        st_next.pend_s1 = {1'b0, exc_pending_new};
        st_next.pend_s2 = st_reg.pend_s1;
        st_next.irq_s1 = {1'b0, irq_taken};
        st_next.irq_s2 = st_reg.irq_s1;
        st_next.mpend_s1 = {1'b0, irq_masked_pend};
        st_next.mpend_s2 = st_reg.mpend_s1;
        st_next.dbg_s1 = {1'b0, debug_req};
        st_next.dbg_s2 = st_reg.dbg_s1;
        st_next.op_done = 1'b0;
        st_next.tt_valid = 1'b0;
        st_next.sg = 1'b0;
        st_next.svc = 1'b0;
        st_next.undef = 1'b0;
        st_next.ev_out = 1'b0;
        st_next.yield = 1'b0;
        // an incoming event while running arms the flag for a later wait
        if (w_ev) begin
            st_next.event_reg = 1'b1;
        end
        case (st_reg.state)
            SHTT_RUN: begin
                if (op_valid) begin
                    case (op_code)
                        SHTT_OP_SEND_EVENT: begin
                            st_next.ev_out = 1'b1;
                            st_next.event_reg = 1'b1;
                            st_next.op_done = 1'b1;
                        end
                        SHTT_OP_SECURE_GATEWAY: begin
                            st_next.sg = 1'b1;
                            st_next.op_done = 1'b1;
                        end
                        SHTT_OP_SVC: begin
                            st_next.svc = 1'b1;
                            st_next.op_done = 1'b1;
                        end
                        SHTT_OP_TEST_TARGET, SHTT_OP_TEST_TARGET_UNPRIV: begin
                            st_next.tt = tt_calc;
                            st_next.tt_valid = 1'b1;
                            st_next.op_done = 1'b1;
                        end
                        SHTT_OP_TEST_TARGET_ALT, SHTT_OP_TEST_TARGET_ALT_UNPRIV: begin
                            if (cur_secure && sec_ext) begin
                                st_next.tt = tt_calc;
                                st_next.tt_valid = 1'b1;
                            end else begin
                                st_next.undef = 1'b1;
                            end
                            st_next.op_done = 1'b1;
                        end
                        SHTT_OP_UNDEF: begin
                            st_next.undef = 1'b1;
                            st_next.op_done = 1'b1;
                        end
                        SHTT_OP_WAIT_EVENT: begin
                            if (st_reg.event_reg || w_ev) begin
                                st_next.event_reg = 1'b0;
                                st_next.op_done = 1'b1;
                            end else begin
                                st_next.state = SHTT_WAIT_EV;
                                st_next.sleeping = 1'b1;
                            end
                        end
                        SHTT_OP_WAIT_INTR: begin
                            st_next.state = SHTT_WAIT_IRQ;
                            st_next.sleeping = 1'b1;
                        end
                        SHTT_OP_YIELD: begin
                            st_next.yield = 1'b1;
                            st_next.op_done = 1'b1;
                        end
                        default: begin
                            st_next.op_done = 1'b1;
                        end
                    endcase
                end
            end
            SHTT_WAIT_EV: begin
                if (w_exc || (wake_pend && w_pend) || (dbg_en && w_dbg) || w_ev) begin
                    st_next.state = SHTT_RUN;
                    st_next.sleeping = 1'b0;
                    st_next.op_done = 1'b1;
                    st_next.event_reg = 1'b0;
                end
            end
            SHTT_WAIT_IRQ: begin
                if (w_irq || w_mpend || (dbg_en && w_dbg)) begin
                    st_next.state = SHTT_RUN;
                    st_next.sleeping = 1'b0;
                    st_next.op_done = 1'b1;
                end
            end
            default: begin
                st_next.state = SHTT_RUN;
                st_next.sleeping = 1'b0;
            end
        endcase
        // apb: access phase with one wait state, answer registered
        st_next.pready = apb_acc;
        st_next.pslverr = 1'b0;
        if (apb_acc) begin
            st_next.prdata = 32'h0000_0000;
            case (paddr)
                `SHTT_OFF_CTRL: begin
                    if (pwrite) begin
                        st_next.ctrl_reg = {29'h0000_0000, pwdata[2:0]};
                    end else begin
                        st_next.prdata = st_reg.ctrl_reg;
                    end
                end
                `SHTT_OFF_STAT: begin
                    st_next.prdata = {30'h0000_0000, st_reg.event_reg, st_reg.sleeping};
                end
                `SHTT_OFF_TTRES: begin
                    st_next.prdata = st_reg.tt;
                end
                default: begin
                    st_next.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.ev_s1 <= 2'b00;
            st_reg.ev_s2 <= 2'b00;
            st_reg.exc_s1 <= 2'b00;
            st_reg.exc_s2 <= 2'b00;
            st_reg.pend_s1 <= 2'b00;
            st_reg.pend_s2 <= 2'b00;
            st_reg.irq_s1 <= 2'b00;
            st_reg.irq_s2 <= 2'b00;
            st_reg.mpend_s1 <= 2'b00;
            st_reg.mpend_s2 <= 2'b00;
            st_reg.dbg_s1 <= 2'b00;
            st_reg.dbg_s2 <= 2'b00;
            st_reg.state <= SHTT_RUN;
            st_reg.event_reg <= 1'b0;
            st_reg.ctrl_reg <= `SHTT_CTRL_RESET;
            st_reg.op_done <= 1'b0;
            st_reg.tt_valid <= 1'b0;
            st_reg.sg <= 1'b0;
            st_reg.svc <= 1'b0;
            st_reg.undef <= 1'b0;
            st_reg.ev_out <= 1'b0;
            st_reg.yield <= 1'b0;
            st_reg.sleeping <= 1'b0;
            st_reg.tt <= 32'h0000_0000;
            st_reg.prdata <= 32'h0000_0000;
            st_reg.pready <= 1'b0;
            st_reg.pslverr <= 1'b0;
        end else begin
            st_reg.ev_s1 <= st_next.ev_s1;
            st_reg.ev_s2 <= st_next.ev_s2;
            st_reg.exc_s1 <= st_next.exc_s1;
            st_reg.exc_s2 <= st_next.exc_s2;
            st_reg.pend_s1 <= st_next.pend_s1;
            st_reg.pend_s2 <= st_next.pend_s2;
            st_reg.irq_s1 <= st_next.irq_s1;
            st_reg.irq_s2 <= st_next.irq_s2;
            st_reg.mpend_s1 <= st_next.mpend_s1;
            st_reg.mpend_s2 <= st_next.mpend_s2;
            st_reg.dbg_s1 <= st_next.dbg_s1;
            st_reg.dbg_s2 <= st_next.dbg_s2;
            st_reg.state <= st_next.state;
            st_reg.event_reg <= st_next.event_reg;
            st_reg.ctrl_reg <= st_next.ctrl_reg;
            st_reg.op_done <= st_next.op_done;
            st_reg.tt_valid <= st_next.tt_valid;
            st_reg.sg <= st_next.sg;
            st_reg.svc <= st_next.svc;
            st_reg.undef <= st_next.undef;
            st_reg.ev_out <= st_next.ev_out;
            st_reg.yield <= st_next.yield;
            st_reg.sleeping <= st_next.sleeping;
            st_reg.tt <= st_next.tt;
            st_reg.prdata <= st_next.prdata;
            st_reg.pready <= st_next.pready;
            st_reg.pslverr <= st_next.pslverr;
        end
    end

    assign op_done = st_reg.op_done;
    assign tt_result = st_reg.tt;
    assign tt_result_valid = st_reg.tt_valid;
    assign flags_write = 1'b0;
    assign sg_valid_target = st_reg.sg;
    assign svc_exc = st_reg.svc;
    assign undef_fault = st_reg.undef;
    assign event_out = st_reg.ev_out;
    assign yield_hint = st_reg.yield;
    assign sleeping = st_reg.sleeping;
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;

    a_sev_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        (op_valid && st_reg.state == SHTT_RUN && op_code == SHTT_OP_SEND_EVENT)
        |=> (event_out && st_reg.event_reg)) else $error("send event did not signal");
    a_svc_raises: assert property (@(posedge core_clk) disable iff (!rst_n)
        (op_valid && st_reg.state == SHTT_RUN && op_code == SHTT_OP_SVC) |=> svc_exc)
        else $error("supervisor call exception missing");
    a_mreg_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        !tt_result[`SHTT_TT_PROTECTION_REGION_VALID] |-> (tt_result[7:0] == 8'h00)) else $error("region nonzero while invalid");
    a_sreg_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        !tt_result[`SHTT_TT_ATTRIBUTION_REGION_VALID] |-> (tt_result[15:8] == 8'h00)) else $error("attribution nonzero while invalid");
    a_nsr_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
        tt_result[`SHTT_TT_NSR] |-> (tt_result[`SHTT_TT_R] && !tt_result[`SHTT_TT_S]))
        else $error("nonsecure readable inconsistent");
    a_ireg_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        !tt_result[`SHTT_TT_IMPL_REGION_VALID] |-> (tt_result[31:24] == 8'h00)) else $error("impl region nonzero");
    a_multi_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
        (op_valid && st_reg.state == SHTT_RUN && op_code == SHTT_OP_TEST_TARGET && mpu_multi)
        |=> (tt_result[`SHTT_TT_R] == 1'b0 && tt_result[`SHTT_TT_PROTECTION_REGION_VALID] == 1'b0))
        else $error("multi hit left permissions");
    a_alt_undef_ns: assert property (@(posedge core_clk) disable iff (!rst_n)
        (op_valid && st_reg.state == SHTT_RUN && op_code == SHTT_OP_TEST_TARGET_ALT && !cur_secure)
        |=> (undef_fault && !tt_result_valid)) else $error("alternate query from nonsecure not undefined");
    a_udf_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
        (op_valid && st_reg.state == SHTT_RUN && op_code == SHTT_OP_UNDEF) |=> undef_fault)
        else $error("undefined fault missing");
    a_wfe_sleeps: assert property (@(posedge core_clk) disable iff (!rst_n)
        (op_valid && st_reg.state == SHTT_RUN && op_code == SHTT_OP_WAIT_EVENT && !st_reg.event_reg && !w_ev)
        |=> (sleeping && !op_done)) else $error("event wait did not suspend");
    a_wfe_skip: assert property (@(posedge core_clk) disable iff (!rst_n)
        (op_valid && st_reg.state == SHTT_RUN && op_code == SHTT_OP_WAIT_EVENT && st_reg.event_reg)
        |=> (op_done && !sleeping && !st_reg.event_reg)) else $error("event wait with flag set stalled");
    a_wfi_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_reg.state == SHTT_WAIT_IRQ && w_irq) |=> (!sleeping && op_done)) else $error("irq wake missed");
    a_no_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
        op_done |-> !flags_write) else $error("flags written");
endmodule
`default_nettype wire
